// >>> mcr_params.svh
// offsets, field positions, reset values and masks of the metering calibration register bank
`ifndef MCR_PARAMS_SVH
`define MCR_PARAMS_SVH

// word index of each register, byte address is four times the index
`define MCR_IDX_PEND      4'h1
`define MCR_IDX_FIRST     4'h4
`define MCR_IDX_LAST      4'he
`define MCR_ROWS          11
`define MCR_IDX_W         4

// array slots of the rows
`define MCR_R_PV          0
`define MCR_R_PC          1
`define MCR_R_SV          2
`define MCR_R_SC          3
`define MCR_R_PUP         4
`define MCR_R_PDN         5
`define MCR_R_SUP         6
`define MCR_R_SDN         7
`define MCR_R_PFE         8
`define MCR_R_SFE         9
`define MCR_R_MASK        10

// field layout shared by the calibration and amp-hour rows, then the front-end row fields
`define MCR_CAL_LSB       0
`define MCR_CAL_W         12
`define MCR_SWL_LSB       12
`define MCR_SAG_LSB       22
`define MCR_LIM_W         10
`define MCR_VON_BIT       0
`define MCR_CON_BIT       16
`define MCR_GAIN_LSB      26
`define MCR_GAIN_W        2

// reset values of the writable bits
`define MCR_RST_VC        32'h003f_f800
`define MCR_RST_AH        32'h0000_0fff
`define MCR_RST_PFE       32'h0c01_0001
`define MCR_RST_SFE       32'h0001_0001
`define MCR_RST_MASK      32'h0000_0000

// writable bits; everything else is reserved
`define MCR_WM_ALL        32'hffff_ffff
`define MCR_WM_CUR        32'h003f_ffff
`define MCR_WM_FE         32'h0c01_0001
// fixed pattern the front-end rows return in their reserved bits
`define MCR_RSV_FE        32'h0326_0326
`define MCR_GAIN_BASE     5'h02

`endif

// >>> mcr_pkg.sv
// types shared by the metering calibration register bank
package mcr_pkg;

	// one ahb-lite request as the slave sees it
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} mcr_ahb_req_t;

	// configuration handed to the metering datapath
	typedef struct packed {
		logic [11:0] pri_volt_gain_cal;
		logic [9:0]  pri_volt_swell_limit;
		logic [9:0]  pri_volt_sag_limit;
		logic [11:0] pri_curr_gain_cal;
		logic [9:0]  pri_curr_swell_limit;
		logic [11:0] sec_volt_gain_cal;
		logic [9:0]  sec_volt_swell_limit;
		logic [9:0]  sec_volt_sag_limit;
		logic [11:0] sec_curr_gain_cal;
		logic [9:0]  sec_curr_swell_limit;
		logic [11:0] pri_amphour_rms_high;
		logic [11:0] pri_amphour_rms_low;
		logic [11:0] sec_amphour_rms_high;
		logic [11:0] sec_amphour_rms_low;
		logic [9:0]  pri_active_pwr_trim;
		logic [9:0]  pri_fund_active_pwr_trim;
		logic [9:0]  pri_reactive_pwr_trim;
		logic [9:0]  pri_apparent_pwr_trim;
		logic [9:0]  sec_active_pwr_trim;
		logic [9:0]  sec_fund_active_pwr_trim;
		logic [9:0]  sec_reactive_pwr_trim;
		logic [9:0]  sec_apparent_pwr_trim;
		logic        pri_volt_chan_on;
		logic        pri_curr_chan_on;
		logic        sec_volt_chan_on;
		logic        sec_curr_chan_on;
		logic [1:0]  pri_curr_amp_gain;
		logic [1:0]  sec_curr_amp_gain;
		logic [31:0] irq_mask;
	} mcr_cfg_t;

endpackage

// >>> mcr_ahb_slave.sv
// ahb-lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/1ps
`default_nettype none
`include "mcr_params.svh"

module mcr_ahb_slave (
	input  wire logic                 i_clk,
	input  wire logic                 i_arst_n,
	input  wire logic                 i_ce,
	input  wire mcr_pkg::mcr_ahb_req_t i_req,
	input  wire logic [31:0]          i_rd_data,
	output logic                      o_hreadyout,
	output logic [31:0]               o_hrdata,
	output logic                      o_hresp,
	output logic                      o_wr_en,
	output logic [`MCR_IDX_W-1:0]     o_idx,
	output logic                      o_idx_hit,
	output logic [31:0]               o_wr_data
);

	logic                  take;
	logic                  wr_pend_q;
	logic                  rd_pend_q;
	logic                  ready_q;
	logic                  hit_q;
	logic [`MCR_IDX_W-1:0] idx_q;
	logic [31:0]           rdata_q;

	// a request is taken only in a nonseq/seq address phase while the bus is ready
	assign take = i_ce & i_req.hsel & i_req.htrans[1] & i_req.hready;

	// reads wait one cycle so a write finishing on the same edge is seen
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			ready_q   <= 1'b1;
			hit_q     <= 1'b0;
			idx_q     <= '0;
			rdata_q   <= '0;
		end else if (i_ce) begin
			wr_pend_q <= take & i_req.hwrite;
			rd_pend_q <= take & ~i_req.hwrite;
			ready_q   <= ~(take & ~i_req.hwrite);
			if (take) begin
				idx_q <= i_req.haddr[`MCR_IDX_W+1:2];
				hit_q <= (i_req.haddr[31:`MCR_IDX_W+2] == '0); // above the window is unmapped
			end
			if (rd_pend_q) begin
				rdata_q <= i_rd_data;
			end
		end
	end

	assign o_hreadyout = ready_q;
	assign o_hrdata    = rdata_q;
	assign o_hresp     = 1'b0; // always okay
	assign o_wr_en     = wr_pend_q & i_ce;
	assign o_idx       = idx_q;
	assign o_idx_hit   = hit_q;
	assign o_wr_data   = i_req.hwdata;

endmodule

`default_nettype wire

// >>> mcr_regs.sv
// metering calibration, threshold, front-end and interrupt mask register bank
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "mcr_params.svh"

module mcr_regs (
	input  wire logic               i_clk,
	input  wire logic               i_arst_n,
	input  wire logic               i_ce,
	input  wire logic               i_hsel,
	input  wire logic [31:0]        i_haddr,
	input  wire logic [1:0]         i_htrans,
	input  wire logic               i_hwrite,
	input  wire logic [2:0]         i_hsize,
	input  wire logic [31:0]        i_hwdata,
	input  wire logic               i_hready,
	input  wire logic [31:0]        i_irq_status,
	output wire logic               o_hreadyout,
	output wire logic [31:0]        o_hrdata,
	output wire logic               o_hresp,
	output wire mcr_pkg::mcr_cfg_t  o_cfg,
	output logic [4:0]              o_pri_curr_gain_factor,
	output logic [4:0]              o_sec_curr_gain_factor,
	output logic                    o_irq
);

	mcr_pkg::mcr_ahb_req_t  req;
	logic                   wr_en;
	logic [`MCR_IDX_W-1:0]  idx;
	logic                   idx_hit;
	logic [31:0]            wr_data;
	logic [31:0]            rd_data;
	logic [31:0]            rows_q [0:`MCR_ROWS-1];
	logic [31:0]            pend_q;
	logic [4:0]             pri_gain_q;
	logic [4:0]             sec_gain_q;
	logic                   irq_q;
	logic                   row_sel;
	logic                   pend_sel;
	logic [`MCR_IDX_W-1:0]  slot;
	logic [31:0]            row_view;
	logic [31:0]            pend_d;

	// reset value of each row's writable bits
	function automatic logic [31:0] row_rst(input int r);
		logic [31:0] v;
		v = `MCR_RST_AH;
		case (r)
			`MCR_R_PV, `MCR_R_PC, `MCR_R_SV, `MCR_R_SC: v = `MCR_RST_VC;
			`MCR_R_PFE:  v = `MCR_RST_PFE;
			`MCR_R_SFE:  v = `MCR_RST_SFE;
			`MCR_R_MASK: v = `MCR_RST_MASK;
			default:     v = `MCR_RST_AH;
		endcase
		return v;
	endfunction

	// which bits of a row software may change
	function automatic logic [31:0] row_wmask(input int r);
		logic [31:0] m;
		m = `MCR_WM_ALL;
		case (r)
			`MCR_R_PC, `MCR_R_SC:   m = `MCR_WM_CUR;
			`MCR_R_PFE, `MCR_R_SFE: m = `MCR_WM_FE;
			default:                m = `MCR_WM_ALL;
		endcase
		return m;
	endfunction

	// fixed value seen in the reserved bits of a row
	function automatic logic [31:0] row_rsv(input int r);
		logic [31:0] f;
		f = '0;
		if (r == `MCR_R_PFE || r == `MCR_R_SFE) begin
			f = `MCR_RSV_FE;
		end
		return f;
	endfunction

	// amplifier gain code 00..11 means x2, x4, x8, x16
	function automatic logic [4:0] gain_factor(input logic [1:0] code);
		return 5'(`MCR_GAIN_BASE << code);
	endfunction

	// pack the bus pins for the slave front end
	assign req.hsel   = i_hsel;
	assign req.haddr  = i_haddr;
	assign req.htrans = i_htrans;
	assign req.hwrite = i_hwrite;
	assign req.hsize  = i_hsize;
	assign req.hwdata = i_hwdata;
	assign req.hready = i_hready;

	mcr_ahb_slave u_bus (
		.i_clk       (i_clk),
		.i_arst_n    (i_arst_n),
		.i_ce        (i_ce),
		.i_req       (req),
		.i_rd_data   (rd_data),
		.o_hreadyout (o_hreadyout),
		.o_hrdata    (o_hrdata),
		.o_hresp     (o_hresp),
		.o_wr_en     (wr_en),
		.o_idx       (idx),
		.o_idx_hit   (idx_hit),
		.o_wr_data   (wr_data)
	);

	// address decode of the data phase index
	assign row_sel  = idx_hit && (idx >= `MCR_IDX_FIRST) && (idx <= `MCR_IDX_LAST);
	assign pend_sel = idx_hit && (idx == `MCR_IDX_PEND);
	assign slot     = idx - `MCR_IDX_FIRST;

	// one flop row per register; reserved bits are never stored
	for (genvar r = 0; r < `MCR_ROWS; r++) begin : g_row
		always_ff @(posedge i_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				rows_q[r] <= row_rst(r);
			end else if (i_ce && wr_en && row_sel && slot == `MCR_IDX_W'(r)) begin
				rows_q[r] <= wr_data & row_wmask(r);
			end
		end
	end

	// read view: stored bits plus the fixed reserved pattern
	assign row_view = row_sel ? ((rows_q[slot] & row_wmask(int'(slot))) | row_rsv(int'(slot))) : '0;
	// unmapped addresses read zero, writes to them are dropped
	assign rd_data  = pend_sel ? pend_q : row_view;

	// primary and secondary voltage/current calibration rows
	assign o_cfg.pri_volt_gain_cal    = rows_q[`MCR_R_PV][`MCR_CAL_LSB +: `MCR_CAL_W];
	assign o_cfg.pri_volt_swell_limit = rows_q[`MCR_R_PV][`MCR_SWL_LSB +: `MCR_LIM_W];
	assign o_cfg.pri_volt_sag_limit   = rows_q[`MCR_R_PV][`MCR_SAG_LSB +: `MCR_LIM_W];
	assign o_cfg.pri_curr_gain_cal    = rows_q[`MCR_R_PC][`MCR_CAL_LSB +: `MCR_CAL_W];
	assign o_cfg.pri_curr_swell_limit = rows_q[`MCR_R_PC][`MCR_SWL_LSB +: `MCR_LIM_W];
	assign o_cfg.sec_volt_gain_cal    = rows_q[`MCR_R_SV][`MCR_CAL_LSB +: `MCR_CAL_W];
	assign o_cfg.sec_volt_swell_limit = rows_q[`MCR_R_SV][`MCR_SWL_LSB +: `MCR_LIM_W];
	assign o_cfg.sec_volt_sag_limit   = rows_q[`MCR_R_SV][`MCR_SAG_LSB +: `MCR_LIM_W];
	assign o_cfg.sec_curr_gain_cal    = rows_q[`MCR_R_SC][`MCR_CAL_LSB +: `MCR_CAL_W];
	assign o_cfg.sec_curr_swell_limit = rows_q[`MCR_R_SC][`MCR_SWL_LSB +: `MCR_LIM_W];

	// amp-hour thresholds share their rows with the power trims
	assign o_cfg.pri_amphour_rms_high = rows_q[`MCR_R_PUP][`MCR_CAL_LSB +: `MCR_CAL_W];
	assign o_cfg.pri_amphour_rms_low  = rows_q[`MCR_R_PDN][`MCR_CAL_LSB +: `MCR_CAL_W];
	assign o_cfg.sec_amphour_rms_high = rows_q[`MCR_R_SUP][`MCR_CAL_LSB +: `MCR_CAL_W];
	assign o_cfg.sec_amphour_rms_low  = rows_q[`MCR_R_SDN][`MCR_CAL_LSB +: `MCR_CAL_W];

	// power offset trims, primary then secondary
	assign o_cfg.pri_active_pwr_trim      = rows_q[`MCR_R_PUP][`MCR_SWL_LSB +: `MCR_LIM_W];
	assign o_cfg.pri_fund_active_pwr_trim = rows_q[`MCR_R_PUP][`MCR_SAG_LSB +: `MCR_LIM_W];
	assign o_cfg.pri_reactive_pwr_trim    = rows_q[`MCR_R_PDN][`MCR_SWL_LSB +: `MCR_LIM_W];
	assign o_cfg.pri_apparent_pwr_trim    = rows_q[`MCR_R_PDN][`MCR_SAG_LSB +: `MCR_LIM_W];
	assign o_cfg.sec_active_pwr_trim      = rows_q[`MCR_R_SUP][`MCR_SWL_LSB +: `MCR_LIM_W];
	assign o_cfg.sec_fund_active_pwr_trim = rows_q[`MCR_R_SUP][`MCR_SAG_LSB +: `MCR_LIM_W];
	assign o_cfg.sec_reactive_pwr_trim    = rows_q[`MCR_R_SDN][`MCR_SWL_LSB +: `MCR_LIM_W];
	assign o_cfg.sec_apparent_pwr_trim    = rows_q[`MCR_R_SDN][`MCR_SAG_LSB +: `MCR_LIM_W];

	// front-end channel enables and amplifier gain codes
	assign o_cfg.pri_volt_chan_on  = rows_q[`MCR_R_PFE][`MCR_VON_BIT];
	assign o_cfg.pri_curr_chan_on  = rows_q[`MCR_R_PFE][`MCR_CON_BIT];
	assign o_cfg.sec_volt_chan_on  = rows_q[`MCR_R_SFE][`MCR_VON_BIT];
	assign o_cfg.sec_curr_chan_on  = rows_q[`MCR_R_SFE][`MCR_CON_BIT];
	assign o_cfg.pri_curr_amp_gain = rows_q[`MCR_R_PFE][`MCR_GAIN_LSB +: `MCR_GAIN_W];
	assign o_cfg.sec_curr_amp_gain = rows_q[`MCR_R_SFE][`MCR_GAIN_LSB +: `MCR_GAIN_W];

	// mask bit n gates status bit n, so the bit order is the event order
	assign o_cfg.irq_mask = rows_q[`MCR_R_MASK];

	// pending events: status flags that software has unmasked
	assign pend_d = i_irq_status & rows_q[`MCR_R_MASK];

	// gain factors and interrupt are registered so outputs come from flops
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pend_q     <= '0;
			irq_q      <= 1'b0;
			pri_gain_q <= gain_factor(2'h3);
			sec_gain_q <= gain_factor(2'h0);
		end else if (i_ce) begin
			pend_q     <= pend_d;
			irq_q      <= |pend_d;
			pri_gain_q <= gain_factor(o_cfg.pri_curr_amp_gain);
			sec_gain_q <= gain_factor(o_cfg.sec_curr_amp_gain);
		end
	end

	assign o_pri_curr_gain_factor = pri_gain_q;
	assign o_sec_curr_gain_factor = sec_gain_q;
	assign o_irq                  = irq_q;

endmodule

`default_nettype wire

// >>> mcr_regs_checker.sv
// concurrent checks on the ports of the metering calibration register bank
`timescale 1ns/1ps
`default_nettype none

module mcr_regs_checker (
	input  wire logic              i_clk,
	input  wire logic              i_arst_n,
	input  wire logic              i_ce,
	input  wire logic              i_hsel,
	input  wire logic [31:0]       i_haddr,
	input  wire logic [1:0]        i_htrans,
	input  wire logic              i_hwrite,
	input  wire logic [31:0]       i_hwdata,
	input  wire logic              i_hready,
	input  wire logic [31:0]       i_irq_status,
	input  wire logic              o_hreadyout,
	input  wire logic [31:0]       o_hrdata,
	input  wire logic              o_hresp,
	input  wire mcr_pkg::mcr_cfg_t o_cfg,
	input  wire logic [4:0]        o_pri_curr_gain_factor,
	input  wire logic [4:0]        o_sec_curr_gain_factor,
	input  wire logic              o_irq
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	// a transfer is only taken with the clock enable high
	wire logic taken = i_hsel & i_htrans[1] & i_hready & i_ce;
	wire logic wr_taken = taken & i_hwrite;
	wire logic rd_taken = taken & ~i_hwrite;

	a_resp_okay: assert property (o_hresp == 1'b0) else $error("bus response not okay");
	a_read_one_wait: assert property (rd_taken |=> !o_hreadyout ##1 o_hreadyout) else $error("read wait wrong");
	a_write_no_wait: assert property (wr_taken |=> o_hreadyout) else $error("write stalled");
	// a write lands one edge after it is taken, so its effect is seen two samples later
	a_cfg_only_written: assert property ((!wr_taken ##1 1'b1) |=> $stable(o_cfg)) else $error("config moved unwritten");
	a_cal_write_lands: assert property (wr_taken && i_haddr == 32'h0000_0010 ##1 i_ce
		|=> o_cfg.pri_volt_gain_cal == $past(i_hwdata[11:0])) else $error("calibration word not written");
	a_irq_masked_or: assert property (i_ce |=> o_irq == |($past(i_irq_status) & $past(o_cfg.irq_mask)))
		else $error("interrupt not status and mask");
	a_pri_gain_map: assert property ($past(i_ce) |->
		o_pri_curr_gain_factor == (5'h02 << $past(o_cfg.pri_curr_amp_gain))) else $error("primary gain factor");
	a_sec_gain_map: assert property ($past(i_ce) |->
		o_sec_curr_gain_factor == (5'h02 << $past(o_cfg.sec_curr_amp_gain))) else $error("secondary gain factor");
	a_rdata_holds: assert property (!$rose(o_hreadyout) |-> $stable(o_hrdata)) else $error("read data moved");

	c_read: cover property (rd_taken ##2 o_hreadyout);
	c_write: cover property (wr_taken);
	c_irq: cover property ($rose(o_irq));
	c_gain_two: cover property (o_pri_curr_gain_factor == 5'h02);
endmodule

bind mcr_regs mcr_regs_checker mcr_regs_checker_inst (
	.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_hsel(i_hsel), .i_haddr(i_haddr),
	.i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
	.i_irq_status(i_irq_status), .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata), .o_hresp(o_hresp),
	.o_cfg(o_cfg), .o_pri_curr_gain_factor(o_pri_curr_gain_factor),
	.o_sec_curr_gain_factor(o_sec_curr_gain_factor), .o_irq(o_irq)
);
`default_nettype wire

// >>> tb.sv
// self-checking testbench of the metering calibration register bank
`timescale 1ns/1ps
`default_nettype none

module tb;
	typedef struct { logic [31:0] a, rst, one, zero; } mcr_tb_row_t;
	logic              i_clk, i_arst_n, ce, hsel, hwrite;
	logic [1:0]        htrans;
	logic [31:0]       haddr, hwdata, status, rd;
	wire logic         hready, hresp, irq;
	wire logic [31:0]  hrdata;
	wire logic [4:0]   pgf, sgf;
	wire mcr_pkg::mcr_cfg_t cfg;
	int                error_cnt = 0;
	int                total_checks = 0;
	// address, reset read, read after all ones, read after all zeros
	mcr_tb_row_t rows [15] = '{
		'{32'h0000_0000, 32'h0, 32'h0, 32'h0}, '{32'h0000_0004, 32'h0, 32'h0, 32'h0},
		'{32'h0000_0010, 32'h003f_f800, 32'hffff_ffff, 32'h0}, '{32'h0000_0014, 32'h003f_f800, 32'h003f_ffff, 32'h0},
		'{32'h0000_0018, 32'h003f_f800, 32'hffff_ffff, 32'h0}, '{32'h0000_001c, 32'h003f_f800, 32'h003f_ffff, 32'h0},
		'{32'h0000_0020, 32'h0000_0fff, 32'hffff_ffff, 32'h0}, '{32'h0000_0024, 32'h0000_0fff, 32'hffff_ffff, 32'h0},
		'{32'h0000_0028, 32'h0000_0fff, 32'hffff_ffff, 32'h0}, '{32'h0000_002c, 32'h0000_0fff, 32'hffff_ffff, 32'h0},
		'{32'h0000_0030, 32'h0f27_0327, 32'h0f27_0327, 32'h0326_0326},
		'{32'h0000_0034, 32'h0327_0327, 32'h0f27_0327, 32'h0326_0326},
		'{32'h0000_0038, 32'h0, 32'hffff_ffff, 32'h0}, '{32'h0000_003c, 32'h0, 32'h0, 32'h0},
		'{32'h0000_0040, 32'h0, 32'h0, 32'h0}};

	// single slave, so its ready is the bus ready
	wire logic hready_out;
	assign hready = hready_out;

	mcr_regs mcr_regs_inst (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(ce), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready), .i_irq_status(status),
		.o_hreadyout(hready_out), .o_hrdata(hrdata), .o_hresp(hresp), .o_cfg(cfg),
		.o_pri_curr_gain_factor(pgf), .o_sec_curr_gain_factor(sgf), .o_irq(irq));

	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	task automatic give_verdict;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one ahb-lite single transfer; entered and left at a rising edge
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		do begin
			@(posedge i_clk);
			n++;
		end while (hready !== 1'b1 && n < 40);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge i_clk);
			n++;
		end while (hready !== 1'b1 && n < 40);
		r = hrdata;
		if (n >= 40) begin
			error_cnt++;
			give_verdict();
		end
	endtask

	initial begin
		i_arst_n = 1'b0; ce = 1'b1; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0;
		haddr = 32'h0; hwdata = 32'h0; status = 32'h0;
		repeat (6) @(posedge i_clk);
		#1 chk(32'(pgf), 32'h10);
		chk(32'(sgf), 32'h2);
		chk({hresp, irq, hready}, 32'h1);
		@(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		// reset value, then all ones, then all zeros, each read straight back
		foreach (rows[i]) begin
			xfer(1'b0, rows[i].a, 32'h0, rd);
			chk(rd, rows[i].rst);
			xfer(1'b1, rows[i].a, 32'hffff_ffff, rd);
			xfer(1'b0, rows[i].a, 32'h0, rd);
			chk(rd, rows[i].one);
			xfer(1'b1, rows[i].a, 32'h0, rd);
			xfer(1'b0, rows[i].a, 32'h0, rd);
			chk(rd, rows[i].zero);
		end
		// every gain code on both channels
		for (int k = 0; k < 4; k++) begin
			xfer(1'b1, 32'h0000_0030, 32'(k) << 26, rd);
			xfer(1'b1, 32'h0000_0034, 32'(k) << 26, rd);
			@(posedge i_clk);
			#1 chk(32'(pgf), 32'h2 << k);
			chk(32'(sgf), 32'h2 << k);
			@(posedge i_clk);
		end
		// each mask bit passes its own event and nothing else
		for (int n = 0; n < 32; n++) begin
			xfer(1'b1, 32'h0000_0038, 32'h1 << n, rd);
			status <= 32'h1 << n;
			repeat (2) @(posedge i_clk);
			#1 chk(32'(irq), 32'h1);
			@(posedge i_clk);
			xfer(1'b0, 32'h0000_0004, 32'h0, rd);
			chk(rd, 32'h1 << n);
			status <= ~(32'h1 << n);
			repeat (2) @(posedge i_clk);
			#1 chk(32'(irq), 32'h0);
			@(posedge i_clk);
		end
		// a frozen clock enable drops the write
		ce <= 1'b0;
		xfer(1'b1, 32'h0000_0020, 32'h0000_0123, rd);
		ce <= 1'b1;
		xfer(1'b0, 32'h0000_0020, 32'h0, rd);
		chk(rd, 32'h0);
		// reset in mid-run restores the defaults
		xfer(1'b1, 32'h0000_0010, 32'h0, rd);
		i_arst_n <= 1'b0;
		@(posedge i_clk);
		#1 chk(32'(cfg.pri_volt_gain_cal), 32'h800);
		@(posedge i_clk);
		i_arst_n <= 1'b1;
		@(posedge i_clk);
		xfer(1'b0, 32'h0000_0010, 32'h0, rd);
		chk(rd, 32'h003f_f800);
		give_verdict();
	end
endmodule
`default_nettype wire
